/* rtl/eeprom_ctl_pkg.sv */
package eeprom_ctl_pkg;

    // Register byte offsets on the APB side
    localparam int           ADDR_W           = 12;
    localparam logic [11:0]  CMD_OFS          = 12'h0B0;
    localparam logic [11:0]  DATA_OFS         = 12'h0B4;
    localparam logic [11:0]  IRQ_STAT_OFS     = 12'h0B8;
    localparam logic [11:0]  IRQ_MASK_OFS     = 12'h0BC;

    // Field positions in eeprom_command_status
    localparam int           BUSY_BIT         = 31;
    localparam int           OP_MSB           = 30;
    localparam int           OP_LSB           = 28;
    localparam int           TIMEOUT_BIT      = 9;
    localparam int           LOADED_BIT       = 8;
    localparam logic [7:0]   ADDR_RESET       = 8'h00;
    localparam logic [7:0]   DATA_RESET       = 8'h00;

    // Interrupt status / mask bit positions
    localparam int           IRQ_W            = 3;
    localparam int           IRQ_DONE         = 0;
    localparam int           IRQ_TIMEOUT      = 1;
    localparam int           IRQ_LOADED       = 2;

    // Serial frame constants
    localparam int           FRAME_W          = 19;
    localparam logic [4:0]   LEN_SHORT        = 5'd11;
    localparam logic [4:0]   LEN_LONG         = 5'd19;
    localparam logic [4:0]   LEN_BYTE         = 5'd8;
    localparam logic [2:0]   HDR_READ         = 3'h6;
    localparam logic [2:0]   HDR_WRITE        = 3'h5;
    localparam logic [2:0]   HDR_ERASE        = 3'h7;
    localparam logic [2:0]   HDR_SPECIAL      = 3'h4;
    localparam logic [7:0]   EW_ENABLE_ADDR   = 8'hC0;
    localparam logic [7:0]   EW_DISABLE_ADDR  = 8'h00;
    localparam logic [7:0]   WRITE_ALL_ADDR   = 8'h40;
    localparam logic [7:0]   ERASE_ALL_ADDR   = 8'h80;
    localparam logic [7:0]   SIGNATURE        = 8'hA5;
    localparam logic [2:0]   LAST_MAC_IDX     = 3'd6;

    // Timing, clock period 25 ns
    localparam int           CLK_NS           = 25;
    localparam int           SK_HALF_NS       = 1000;
    localparam int           CS_LOW_NS        = 250;
    localparam int           TIMEOUT_MS       = 30;
    // Synchroniser lag plus the memory's turn-on after chip select rises
    localparam int           POLL_SETTLE_CYC  = 4;
    localparam int           SK_HALF_CYC      = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int           CS_LOW_CYC       = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int           TIMEOUT_CYC      = TIMEOUT_MS * 1000000 / CLK_NS;
    localparam int           WAIT_W           = 21;
    localparam int           DIV_W            = 6;

    // Command field encoding
    typedef enum logic [2:0] {
        OP_READ, OP_EW_DISABLE, OP_EW_ENABLE, OP_WRITE,
        OP_WRITE_ALL, OP_ERASE, OP_ERASE_ALL, OP_RELOAD
    } op_t;

    // Controller sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_SEND, ST_RECV, ST_GAP, ST_POLL
    } state_t;

    // Pins driven toward the memory
    typedef struct packed {
        logic cs;
        logic sk;
        logic data_o;
        logic data_oe;
    } pin_out_t;

endpackage

/* rtl/eeprom_controller.sv */
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - No response in 30 ms: abort to idle
// - Time-out sets sticky bit 9, write-one clears
// - Data pin high: no time-out, busy clears
// - Only erase/write commands can time out
// - Valid memory and address loaded sets bit 8
// - Byte address field bits 7-0, reset zero
// - Data register bits 7-0, reset zero
module eeprom_controller
    import eeprom_ctl_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    output logic      [47:0]       station_addr,
    output pin_out_t               eeprom_pins,
    input  wire logic              eeprom_data_pin_i
);

    // Bus decode
    logic          setup;          // First cycle of a transfer
    logic          wr_acc;         // Write takes effect
    logic          mapped;         // Address hits a register
    logic          busy;           // Command in progress
    logic [31:0]   rd_mux;         // Read value before the flop
    logic          err_r;          // Unmapped, seen in setup
    logic [31:0]   prdata_r;       // Registered read data

    // Software visible state
    logic [7:0]    addr_r;         // Location field
    logic [7:0]    data_r;         // Data byte
    op_t           cmd_op_r;       // Command field
    logic          start_r;        // Start request pulse
    logic          timeout_r;      // Sticky time-out flag
    logic          loaded_r;       // Sticky address-loaded flag
    logic [IRQ_W-1:0] irq_stat_r;  // Sticky event bits
    logic [IRQ_W-1:0] irq_mask_r;  // Enables onto irq

    // Sequencer
    state_t             state_r;
    op_t                op_r;      // Command being run
    logic               boot_r;    // Power-up reload pending
    logic [FRAME_W-1:0] sh_r;      // Outgoing frame, MSB first
    logic [7:0]         rx_r;      // Incoming byte
    logic [4:0]         cnt_r;     // Bits left in this phase
    logic               phase_r;   // Serial clock is high
    logic               poll_r;    // Ready poll still to come
    logic               more_r;    // Reload has bytes left
    logic [2:0]         idx_r;     // Reload location
    logic [WAIT_W-1:0]  wait_r;    // Gap and time-out counter
    logic [DIV_W-1:0]   div_r;     // Serial clock divider
    logic               tick;      // Half serial period enable
    logic               done_p;    // Command finished
    logic               tmo_p;     // Time-out happened
    logic               load_p;    // Station address loaded
    logic               rd_p;      // Read byte is ready
    pin_out_t           pins_r;    // Pin flops
    logic [47:0]        mac_r;     // Loaded station address
    logic               din_m_r;   // Synchroniser stage one
    logic               din_s_r;   // Synchronised data pin

    localparam logic [WAIT_W-1:0] TMO_LAST =
        WAIT_W'(TIMEOUT_CYCLES - 1);
    localparam logic [WAIT_W-1:0] GAP_LAST = WAIT_W'(CS_LOW_CYC - 1);
    localparam logic [DIV_W-1:0]  DIV_LAST = DIV_W'(SK_HALF_CYC - 1);
    // Pin level before this count still shows the released bus
    localparam logic [WAIT_W-1:0] SETTLE_LAST =
        WAIT_W'(POLL_SETTLE_CYC - 1);

    // Builds start bit, opcode, address and optional data
    function automatic logic [FRAME_W-1:0] make_frame(
        input op_t op, input logic [7:0] a, input logic [7:0] d);
        logic [2:0] hdr;
        logic [7:0] ad;
        hdr = HDR_SPECIAL;
        ad  = a;
        unique case (op)
            OP_READ, OP_RELOAD: hdr = HDR_READ;
            OP_WRITE:           hdr = HDR_WRITE;
            OP_ERASE:           hdr = HDR_ERASE;
            OP_EW_ENABLE:       ad  = EW_ENABLE_ADDR;
            OP_EW_DISABLE:      ad  = EW_DISABLE_ADDR;
            OP_WRITE_ALL:       ad  = WRITE_ALL_ADDR;
            OP_ERASE_ALL:       ad  = ERASE_ALL_ADDR;
        endcase
        return {hdr, ad, d};
    endfunction

    // Commands that program the array and wait for ready
    function automatic logic is_prog(input op_t op);
        return op == OP_WRITE || op == OP_WRITE_ALL ||
               op == OP_ERASE || op == OP_ERASE_ALL;
    endfunction

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign mapped = paddr == CMD_OFS || paddr == DATA_OFS ||
                    paddr == IRQ_STAT_OFS || paddr == IRQ_MASK_OFS;
    // Busy also covers the pulses around the state change
    assign busy   = state_r != ST_IDLE || boot_r || start_r || done_p;
    assign tick   = div_r == DIV_LAST;

    // Zero wait states; error only on unmapped access
    assign pready  = 1'b1;
    assign pslverr = psel & penable & err_r;
    assign prdata  = prdata_r;
    assign irq     = |(irq_stat_r & irq_mask_r);
    assign eeprom_pins  = pins_r;
    assign station_addr = mac_r;

    // Read multiplexer, reserved bits read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == CMD_OFS) begin
            rd_mux[BUSY_BIT]        = busy;
            rd_mux[OP_MSB:OP_LSB]   = cmd_op_r;
            rd_mux[TIMEOUT_BIT]     = timeout_r;
            rd_mux[LOADED_BIT]      = loaded_r;
            rd_mux[7:0]             = addr_r;
        end else if (paddr == DATA_OFS) begin
            rd_mux[7:0] = data_r;
        end else if (paddr == IRQ_STAT_OFS) begin
            rd_mux[IRQ_W-1:0] = irq_stat_r;
        end else if (paddr == IRQ_MASK_OFS) begin
            rd_mux[IRQ_W-1:0] = irq_mask_r;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            err_r    <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            err_r    <= ~mapped;
        end
    end

    // Command field, location and start; ignored while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r   <= ADDR_RESET;
            cmd_op_r <= OP_READ;
            start_r  <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (wr_acc && paddr == CMD_OFS && !busy) begin
                if (pstrb[0])
                    addr_r <= pwdata[7:0];
                if (pstrb[3]) begin
                    cmd_op_r <= op_t'(pwdata[OP_MSB:OP_LSB]);
                    start_r  <= pwdata[BUSY_BIT];
                end
            end
        end
    end

    // Data byte: software writes when idle, reads fill it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= DATA_RESET;
        end else if (rd_p) begin
            data_r <= rx_r;
        end else if (wr_acc && paddr == DATA_OFS && !busy && pstrb[0]) begin
            data_r <= pwdata[7:0];
        end
    end

    // Sticky flags; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_r <= 1'b0;
            loaded_r  <= 1'b0;
        end else begin
            if (tmo_p)
                timeout_r <= 1'b1;
            else if (wr_acc && paddr == CMD_OFS && pstrb[1] &&
                     pwdata[TIMEOUT_BIT])
                timeout_r <= 1'b0;
            if (load_p)
                loaded_r <= 1'b1;
            else if (wr_acc && paddr == CMD_OFS && pstrb[1] &&
                     pwdata[LOADED_BIT])
                loaded_r <= 1'b0;
        end
    end

    // Interrupt status and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (wr_acc && paddr == IRQ_STAT_OFS && pwdata[i])
                    irq_stat_r[i] <= 1'b0;
            end
            if (done_p)
                irq_stat_r[IRQ_DONE] <= 1'b1;
            if (tmo_p)
                irq_stat_r[IRQ_TIMEOUT] <= 1'b1;
            if (load_p)
                irq_stat_r[IRQ_LOADED] <= 1'b1;
            if (wr_acc && paddr == IRQ_MASK_OFS && pstrb[0])
                irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    // Two-flop synchroniser on the data pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_m_r <= 1'b0;
            din_s_r <= 1'b0;
        end else begin
            din_m_r <= eeprom_data_pin_i;
            din_s_r <= din_m_r;
        end
    end

    // Serial clock divider, free running for simplicity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_r <= '0;
        else
            div_r <= tick ? '0 : div_r + 1'b1;
    end

    // Command sequencer and pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            op_r    <= OP_READ;
            boot_r  <= 1'b1;
            sh_r    <= '0;
            rx_r    <= 8'h00;
            cnt_r   <= '0;
            phase_r <= 1'b0;
            poll_r  <= 1'b0;
            more_r  <= 1'b0;
            idx_r   <= '0;
            wait_r  <= '0;
            done_p  <= 1'b0;
            tmo_p   <= 1'b0;
            load_p  <= 1'b0;
            rd_p    <= 1'b0;
            pins_r  <= '0;
            mac_r   <= '0;
        end else begin
            done_p <= 1'b0;
            tmo_p  <= 1'b0;
            load_p <= 1'b0;
            rd_p   <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    // Power-up reload goes before any software command
                    if (boot_r || start_r) begin
                        op_r    <= boot_r ? OP_RELOAD : cmd_op_r;
                        boot_r  <= 1'b0;
                        idx_r   <= '0;
                        sh_r    <= boot_r ? make_frame(OP_RELOAD, 8'h00, 8'h00)
                                          : make_frame(cmd_op_r, addr_r, data_r);
                        cnt_r   <= (!boot_r && (cmd_op_r == OP_WRITE ||
                                    cmd_op_r == OP_WRITE_ALL))
                                   ? LEN_LONG : LEN_SHORT;
                        poll_r  <= !boot_r && is_prog(cmd_op_r);
                        phase_r <= 1'b0;
                        pins_r  <= '{cs: 1'b1, sk: 1'b0, data_o: 1'b0,
                                     data_oe: 1'b1};
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    pins_r.data_o <= sh_r[FRAME_W-1];
                    if (tick) begin
                        phase_r   <= ~phase_r;
                        pins_r.sk <= ~phase_r;
                        if (phase_r) begin
                            sh_r  <= {sh_r[FRAME_W-2:0], 1'b0};
                            cnt_r <= cnt_r - 1'b1;
                            if (cnt_r == 5'd1) begin
                                // Reads turn the pin round
                                if (op_r == OP_READ || op_r == OP_RELOAD) begin
                                    pins_r.data_oe <= 1'b0;
                                    cnt_r   <= LEN_BYTE;
                                    state_r <= ST_RECV;
                                end else begin
                                    pins_r  <= '0;
                                    wait_r  <= '0;
                                    state_r <= ST_GAP;
                                end
                            end
                        end
                    end
                end
                ST_RECV: begin
                    if (tick) begin
                        phase_r   <= ~phase_r;
                        pins_r.sk <= ~phase_r;
                        if (phase_r) begin
                            rx_r  <= {rx_r[6:0], din_s_r};
                            cnt_r <= cnt_r - 1'b1;
                            if (cnt_r == 5'd1) begin
                                pins_r  <= '0;
                                wait_r  <= '0;
                                state_r <= ST_GAP;
                                more_r  <= 1'b0;
                                if (op_r == OP_READ) begin
                                    rd_p <= 1'b1;
                                end else if (idx_r == 3'd0) begin
                                    // Blank memory reads all ones: no load
                                    more_r <= {rx_r[6:0], din_s_r} == SIGNATURE;
                                end else begin
                                    mac_r[8*(idx_r-3'd1) +: 8] <=
                                        {rx_r[6:0], din_s_r};
                                    more_r <= idx_r != LAST_MAC_IDX;
                                    load_p <= idx_r == LAST_MAC_IDX;
                                end
                            end
                        end
                    end
                end
                ST_GAP: begin
                    // Chip select low between frames
                    wait_r <= wait_r + 1'b1;
                    if (wait_r == GAP_LAST) begin
                        wait_r <= '0;
                        if (poll_r) begin
                            poll_r  <= 1'b0;
                            pins_r.cs <= 1'b1;
                            state_r <= ST_POLL;
                        end else if (more_r) begin
                            idx_r   <= idx_r + 1'b1;
                            sh_r    <= make_frame(OP_READ, {5'h00, idx_r + 3'd1},
                                                  8'h00);
                            cnt_r   <= LEN_SHORT;
                            phase_r <= 1'b0;
                            pins_r  <= '{cs: 1'b1, sk: 1'b0, data_o: 1'b0,
                                         data_oe: 1'b1};
                            state_r <= ST_SEND;
                        end else begin
                            done_p  <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_POLL: begin
                    // Ready trusted only once the pin has settled
                    wait_r <= wait_r + 1'b1;
                    if (din_s_r && wait_r >= SETTLE_LAST) begin
                        pins_r  <= '0;
                        done_p  <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (wait_r == TMO_LAST) begin
                        pins_r  <= '0;
                        done_p  <= 1'b1;
                        tmo_p   <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Checks next to the logic
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    timeout_abort_a: assert property (
        state_r == ST_POLL && !din_s_r && wait_r == TMO_LAST
        |=> state_r == ST_IDLE && tmo_p ##1 timeout_r)
        else $error("time-out did not abort to idle");
    timeout_sticky_a: assert property (
        timeout_r && !(wr_acc && paddr == CMD_OFS && pstrb[1] &&
        pwdata[TIMEOUT_BIT]) |=> timeout_r)
        else $error("time-out flag dropped without clear");
    timeout_clear_a: assert property (
        wr_acc && paddr == CMD_OFS && pstrb[1] && pwdata[TIMEOUT_BIT]
        && !tmo_p |=> !timeout_r)
        else $error("time-out flag not cleared by write one");
    ready_high_a: assert property (
        state_r == ST_POLL && din_s_r && wait_r >= SETTLE_LAST
        |=> state_r == ST_IDLE && done_p && !tmo_p ##1 !busy)
        else $error("ready pin did not end command");
    prog_only_a: assert property (
        state_r == ST_POLL |-> is_prog(op_r))
        else $error("non-programming command waits for ready");
    loaded_set_a: assert property (
        load_p |-> op_r == OP_RELOAD ##1 loaded_r)
        else $error("address-loaded flag not set");
    addr_write_a: assert property (
        wr_acc && paddr == CMD_OFS && !busy && pstrb[0]
        |=> addr_r == $past(pwdata[7:0]))
        else $error("location field not written");
    data_read_a: assert property (
        rd_p |-> op_r == OP_READ ##1 data_r == $past(rx_r))
        else $error("read byte not stored");
    frame_len_a: assert property (
        state_r == ST_IDLE && start_r && !boot_r &&
        cmd_op_r == OP_WRITE |=> cnt_r == LEN_LONG && state_r == ST_SEND)
        else $error("write frame length wrong");

    timeout_c: cover property (tmo_p);
    read_done_c: cover property (rd_p ##[1:40] done_p);
    reload_c: cover property (load_p);
    prog_done_c: cover property (state_r == ST_POLL ##1 done_p && !tmo_p);

endmodule

`default_nettype wire

/* tb/eeprom_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial memory: shifts on sk rise, then busy low and ready high
module eeprom_mem_model
    import eeprom_ctl_pkg::*;
(
    input  wire pin_out_t pins,
    input  wire logic     pclk,
    output logic          mem_oe,
    output logic          mem_d
);
    logic [7:0]  mem [256];
    logic [18:0] sr = 0;
    logic [4:0]  cnt = 0;
    logic [5:0]  bc = 0;
    logic [2:0]  k = 0;
    logic        skq = 0, csq = 0, ew = 0, prog = 0;
    // Header and location depend on frame length
    wire logic [2:0] h = cnt == 19 ? sr[18:16] : sr[10:8];
    wire logic [7:0] a = cnt == 19 ? sr[15:8] : sr[7:0];
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i < 7 ? 8'(8'h11 * i) : 8'h00;
        mem[0] = SIGNATURE;
    end
    // Decode at chip-select fall; refuse programming while disabled
    always @(posedge pclk) begin
        skq <= pins.sk;
        csq <= pins.cs;
        if (!pins.cs) begin
            {cnt, k, mem_oe, bc} <= '0;
            if (csq && prog) prog <= 0;
            else if (csq) begin
                if (h == HDR_SPECIAL && a == EW_ENABLE_ADDR) ew <= 1;
                if (h == HDR_SPECIAL && a == EW_DISABLE_ADDR) ew <= 0;
                prog <= ew && h != HDR_READ && (h[0] ||
                        a == WRITE_ALL_ADDR || a == ERASE_ALL_ADDR);
                for (int i = 0; i < 256; i++)
                    if (ew && h == HDR_SPECIAL &&
                        (a == WRITE_ALL_ADDR || a == ERASE_ALL_ADDR))
                        mem[i] <= a == ERASE_ALL_ADDR ? 8'hFF : sr[7:0];
                if (ew && h[0]) mem[a] <= h == HDR_ERASE ? 8'hFF : sr[7:0];
            end
        end else if (prog) begin
            // Busy low for 40 clocks, then ready
            mem_oe <= 1;
            mem_d <= bc == 40;
            if (bc != 40) bc <= bc + 1;
        end else if (pins.sk && !skq) begin
            if (pins.data_oe) begin
                sr <= {sr[17:0], pins.data_o};
                cnt <= cnt + 1;
            end else if (cnt == 11 && h == HDR_READ) begin
                mem_oe <= 1;
                mem_d <= mem[a][~k];
                k <= k + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/serial_eeprom_command_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_control_bench
    import eeprom_ctl_pkg::*;
;
    typedef struct packed {logic err; logic [31:0] m, e;} note_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, d;
    logic        pready, pslverr, irq, mem_oe, mem_d, present = 1, pull = 1;
    logic [47:0] station_addr;
    logic [7:0]  a;
    pin_out_t    pins;
    note_t       nq[$];
    int          n_errors = 0, checks = 0, cyc = 0, seed = 60;
    // Data pin: controller, else memory, else board pull
    wire logic pin_i = pins.data_oe ? pins.data_o
                     : (present && mem_oe ? mem_d : pull);
    always #12.5 pclk = ~pclk;
    eeprom_controller #(.TIMEOUT_CYCLES(200)) eeprom_controller_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .station_addr(station_addr), .eeprom_pins(pins),
        .eeprom_data_pin_i(pin_i));
    eeprom_mem_model eeprom_mem_model_i (.pins(pins), .pclk(pclk),
        .mem_oe(mem_oe), .mem_d(mem_d));
    task automatic cmp(input logic [47:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard
    always @(posedge pclk) if (++cyc == 80000) begin
        n_errors++;
        print_verdict();
    end
    // Monitor takes the oldest note at each completed read
    always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
        if (nq.size() == 0) cmp(1, 0, "no note");
        else cmp({pslverr, prdata & nq[0].m}, {nq[0].err, nq[0].e & nq[0].m},
                 "read");
        if (nq.size() != 0) void'(nq.pop_front());
    end
    // Setup, then access held until pready
    task automatic xfer(input logic w, input logic [11:0] ad,
                        input logic [31:0] wd);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, penable} <= {1'b1, w, ad, wd, 1'b0};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] e, m,
                      input logic err);
        nq.push_back('{err, m, e});
        xfer(0, ad, 0);
    endtask
    task automatic cmd(input op_t o, input logic [7:0] l);
        xfer(1, CMD_OFS, {1'b1, o, 20'h0, l});
        for (int i = 0; i < 5000 && (i == 0 || q[31]); i++) rd(CMD_OFS, 0, 0, 0);
        cmp(q[31], 0, "busy");
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        cmp(irq, e, "irq");
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rd(DATA_OFS, 0, 32'hFF, 0);
        rd(CMD_OFS, 32'h8000_0000, 32'h8000_00FF, 0);
        for (int i = 0; i < 5000 && (i == 0 || q[31]); i++) rd(CMD_OFS, 0, 0, 0);
        rd(CMD_OFS, 32'h100, 32'h8000_0300, 0);
        cmp(station_addr, 48'h6655_4433_2211, "station");
        rd(12'h0C0, 0, 32'hFFFF_FFFF, 1);
        xfer(1, IRQ_MASK_OFS, 32'h4);
        chk_irq(1);
        xfer(1, IRQ_STAT_OFS, 32'h7);
        chk_irq(0);
        xfer(1, CMD_OFS, 32'h100);
        rd(CMD_OFS, 0, 32'h100, 0);
        $display("power-up load test done");
        d = $random(seed) & 32'hFF;
        a = 8'($random(seed));
        cmd(OP_EW_ENABLE, 0);
        xfer(1, DATA_OFS, d);
        cmd(OP_WRITE, a);
        rd(CMD_OFS, {24'h0, a}, 32'h8000_03FF, 0);
        xfer(1, DATA_OFS, 0);
        cmd(OP_READ, a);
        rd(DATA_OFS, d, 32'hFF, 0);
        rd(IRQ_STAT_OFS, 1, 1, 0);
        cmd(OP_WRITE_ALL, 0);
        xfer(1, DATA_OFS, 0);
        cmd(OP_READ, ~a);
        rd(DATA_OFS, d, 32'hFF, 0);
        $display("write read test done");
        {present, pull} <= 2'b00;
        xfer(1, IRQ_MASK_OFS, 32'h2);
        for (int i = 0; i < 8; i++) begin
            cmd(op_t'(i), a);
            rd(CMD_OFS, (i > 2 && i < 7) << 9, 32'h8000_0300, 0);
            chk_irq(i > 2 && i < 7);
            xfer(1, CMD_OFS, 32'h200);
            xfer(1, IRQ_STAT_OFS, 32'h7);
            rd(CMD_OFS, 0, 32'h200, 0);
        end
        $display("pulled low test done");
        pull <= 1;
        cmd(OP_WRITE, a);
        rd(CMD_OFS, 0, 32'h8000_0300, 0);
        cmd(OP_RELOAD, 0);
        rd(CMD_OFS, 0, 32'h8000_0300, 0);
        $display("pulled high test done");
        print_verdict();
    end
endmodule
`default_nettype wire
